// File: hdl/sfl_lock_ctrl.sv
// Purpose: classify, lock, store and restore camera settings for a set sequencer
// Assumes: all control inputs come from logic on core_clk_i
// Notes: dependency web is given as a flat matrix, bit i*NF+j = i depends on j
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - a direct enable applies to every set, not only the selected one.
// - each direct setting value is stored separately per set.
// - implied setting values are also stored per set.
// - implied settings writable in setup, refused while running.
// - fixed settings keep one shared value, never restored per set.
// - fixed settings refuse writes in setup and while running.
// - automatic controls are held off while running.
// - automatic controls outside the fixed class stay writable during setup.
// - unrelated settings are never locked or changed by the sequencer.
// - storing a set captures every active setting value.
// - entering setup resolves implied and fixed, and locks fixed at once.
// - fixed classification is transitive across the dependency web; implied covers direct dependents only.
// - storage for up to eight sequencer sets.
// - leaving setup checks the configuration and reports validity.
// - run on locks all sequenced settings and loads the start set.
module sfl_lock_ctrl import sfl_pkg::*; #(
  parameter int NF = SFL_NUM_FEAT,
  parameter int DW = SFL_DATA_W,
  parameter int NS = SFL_NUM_SETS,
  localparam int FW = $clog2(NF),
  localparam int SW = $clog2(NS)
) (
  input wire logic core_clk_i, // device clock
  input wire logic reset_i, // async reset, active high
  input wire logic [NF*NF-1:0] dep_i, // dependency web
  input wire logic [NF-1:0] auto_feat_i, // settings that are automatic controls
  input wire logic [FW-1:0] direct_setting_picker_i, // setting for enable write
  input wire logic direct_setting_enable_bit_i, // enable value to write
  input wire logic enable_wr_i, // pulse: write the enable bit
  input wire logic setup_phase_switch_i, // level: setup phase requested
  input wire logic run_phase_switch_i, // level: run requested
  input wire logic wr_en_i, // pulse: write a setting
  input wire logic [FW-1:0] wr_feat_i, // setting to write
  input wire logic [DW-1:0] wr_data_i, // value to write
  input wire logic [SW-1:0] set_sel_i, // selected set
  input wire logic save_i, // pulse: store live values into selected set
  input wire logic load_i, // pulse: restore selected set
  input wire logic [SW-1:0] start_set_i, // set loaded when the run starts
  output logic [NF*DW-1:0] feat_val_o, // effective setting values
  output logic [NF-1:0] direct_o, // direct class
  output logic [NF-1:0] implied_o, // implied class
  output logic [NF-1:0] fixed_o, // fixed class
  output logic [NF-1:0] lock_o, // write lock per setting
  output logic setup_check_result_o, // configuration valid
  output logic [1:0] phase_o, // current phase code
  output logic [SW-1:0] active_set_o, // last loaded set
  output logic wr_rej_o // pulse: last write refused
);

  // ==========================================================================
  // state
  sfl_phase_e phase_q, phase_d;
  logic [NF-1:0] dir_q, impl_q, fix_q;
  logic [NF-1:0] impl_c, fix_c;
  logic [DW-1:0] live_q [NF];
  logic [DW-1:0] set_q [NS][NF];
  logic [NS-1:0] saved_q;
  logic valid_q, rej_q;
  logic [SW-1:0] act_q;
  logic [NF*DW-1:0] out_q;

  // prerequisites of a group: every j that some member i depends on
  function automatic logic [NF-1:0] prereq(input logic [NF-1:0] s,
                                            input logic [NF*NF-1:0] d);
    logic [NF-1:0] p;
    p = '0;
    for (int i = 0; i < NF; i++) begin
      for (int j = 0; j < NF; j++) begin
        if (s[i] && d[i*NF+j]) begin
          p[j] = 1'b1;
        end
      end
    end
    return p;
  endfunction

  // ==========================================================================
  // classification
  // transitive closure
  // closing over NF passes covers the longest possible chain of prerequisites
  always_comb begin
    impl_c = '0;
    for (int i = 0; i < NF; i++) begin
      for (int j = 0; j < NF; j++) begin
        if (dep_i[i*NF+j] && dir_q[j]) begin
          impl_c[i] = 1'b1;
        end
      end
    end
    impl_c = impl_c & ~dir_q;
    fix_c = prereq(dir_q | impl_c, dep_i);
    for (int a = 0; a < NF; a++) begin
      fix_c = fix_c | prereq(fix_c, dep_i);
    end
    fix_c = fix_c & ~(dir_q | impl_c);
  end

  // ==========================================================================
  // phase control
  wire logic in_setup = (phase_q == SFL_PH_SETUP);
  wire logic in_run = (phase_q == SFL_PH_RUN);
  wire logic go_run = (phase_q == SFL_PH_IDLE) && run_phase_switch_i && valid_q;
  wire logic go_setup = (phase_q == SFL_PH_IDLE) && setup_phase_switch_i && !run_phase_switch_i;
  wire logic leave_setup = in_setup && !setup_phase_switch_i;
  wire logic check_ok = saved_q[start_set_i] && (|dir_q);

  // run needs a valid configuration; a run request is ignored otherwise
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      SFL_PH_IDLE: begin
        if (go_run) begin
          phase_d = SFL_PH_RUN;
        end else if (go_setup) begin
          phase_d = SFL_PH_SETUP;
        end
      end
      SFL_PH_SETUP: begin
        if (!setup_phase_switch_i) begin
          phase_d = SFL_PH_IDLE;
        end
      end
      SFL_PH_RUN: begin
        if (!run_phase_switch_i) begin
          phase_d = SFL_PH_IDLE;
        end
      end
      default: begin
        phase_d = SFL_PH_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // locks
  wire logic [NF-1:0] forced_w = auto_feat_i & ~(dir_q | impl_q | fix_q);
  // fixed locked in setup and run
  wire logic [NF-1:0] lock_w = in_run ? (dir_q | impl_q | fix_q | forced_w) :
                               in_setup ? fix_q : '0;
  wire logic wr_ok = wr_en_i && !lock_w[wr_feat_i];
  // direct enables are global, changed only outside setup and run
  wire logic en_ok = enable_wr_i && (phase_q == SFL_PH_IDLE);
  wire logic [NF-1:0] restore_w = dir_q | impl_q;

  // class frozen on setup entry
  // classes track the web while idle and freeze the moment setup or run starts
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dir_q <= '0;
      impl_q <= '0;
      fix_q <= '0;
    end else begin
      if (en_ok) begin
        dir_q[direct_setting_picker_i] <= direct_setting_enable_bit_i;
      end
      if (phase_q == SFL_PH_IDLE) begin
        impl_q <= impl_c;
        fix_q <= fix_c;
      end
    end
  end

  // phase, validity and reject flag
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q <= SFL_PH_IDLE;
      valid_q <= SFL_VALID_RST;
      rej_q <= SFL_REJ_RST;
    end else begin
      phase_q <= phase_d;
      if (leave_setup) begin
        valid_q <= check_ok;
      end
      rej_q <= wr_en_i && !wr_ok;
    end
  end

  // ==========================================================================
  // live values and set store
  // eight sets by default
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NF; i++) begin
        live_q[i] <= '0;
      end
      saved_q <= '0;
      act_q <= '0;
    end else begin
      if (go_run || load_i) begin
        act_q <= go_run ? start_set_i : set_sel_i;
        for (int i = 0; i < NF; i++) begin
          if (restore_w[i]) begin
            live_q[i] <= set_q[go_run ? start_set_i : set_sel_i][i];
          end
        end
      end else if (wr_ok) begin
        live_q[wr_feat_i] <= wr_data_i;
      end
      if (save_i) begin
        saved_q[set_sel_i] <= 1'b1;
      end
    end
  end

  // set memory carries no reset; saved_q tells which entries hold data
  always_ff @(posedge core_clk_i) begin
    if (save_i) begin
      for (int i = 0; i < NF; i++) begin
        set_q[set_sel_i][i] <= live_q[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < NF; i++) begin
        out_q[i*DW +: DW] <= (in_run && auto_feat_i[i]) ? '0 : live_q[i];
      end
    end
  end

  // outputs
  assign feat_val_o = out_q;
  assign direct_o = dir_q;
  assign implied_o = impl_q;
  assign fixed_o = fix_q;
  assign lock_o = lock_w;
  assign setup_check_result_o = valid_q;
  assign phase_o = phase_q;
  assign active_set_o = act_q;
  assign wr_rej_o = rej_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // non-zero flag per shown value, read by the forced-off check
  logic [NF-1:0] out_nz;
  always_comb begin
    for (int i = 0; i < NF; i++) out_nz[i] = |out_q[i*DW +: DW];
  end

  sequence s_enter_setup;
    (phase_q == SFL_PH_IDLE) ##1 in_setup;
  endsequence

  a_fixed_locked: assert property ((in_setup || in_run) |-> ((lock_w & fix_q) == fix_q))
    else $error("fixed setting not locked");
  a_implied_open: assert property (in_setup |-> ((lock_w & impl_q) == '0))
    else $error("implied setting locked in setup");
  a_forced_open: assert property (in_setup |-> ((lock_w & forced_w) == '0))
    else $error("forced setting locked in setup");
  a_free_never_lock: assert property (
      (lock_w & ~(dir_q | impl_q | fix_q | auto_feat_i)) == '0)
    else $error("unrelated setting locked");
  a_class_resolve: assert property (s_enter_setup |-> (fix_q == $past(fix_c)) &&
      (impl_q == $past(impl_c))) else $error("classes not resolved on setup entry");
  a_class_frozen: assert property (in_setup |=> !in_setup || $stable({fix_q, impl_q}))
    else $error("classes changed during setup");
  a_locked_write: assert property ((wr_en_i && lock_w[wr_feat_i] && !load_i && !go_run)
      |=> (live_q[$past(wr_feat_i)] == $past(live_q[wr_feat_i])) && rej_q)
    else $error("locked write took effect");
  a_auto_off: assert property (in_run |=> (out_nz & $past(auto_feat_i)) == '0)
    else $error("automatic control not held off");
  a_check_result: assert property (leave_setup |=> (valid_q == $past(check_ok)))
    else $error("setup check not reported");
  a_run_load: assert property (go_run |=> in_run && (act_q == $past(start_set_i)))
    else $error("start set not loaded on run");
  a_save_mark: assert property (save_i |=> saved_q[$past(set_sel_i)])
    else $error("set not marked stored");
  a_transitive: assert property ((prereq(fix_c, dep_i) & ~(dir_q | impl_c | fix_c)) == '0)
    else $error("fixed class not closed");

endmodule // sfl_lock_ctrl
`default_nettype wire

// File: common/sfl_pkg.sv
// Purpose: shared constants for the sequencer setting lock controller
// Assumes: one clock, asynchronous active-high reset
// Notes: phase codes follow a gray path idle -> setup, idle -> run
package sfl_pkg;
  // ==========================================================================
  // sizes
  localparam int SFL_NUM_FEAT = 8;   // settings under control
  localparam int SFL_DATA_W = 16;    // width of one setting value
  localparam int SFL_NUM_SETS = 8;   // sequencer sets that can be stored
  // ==========================================================================
  // reset values
  localparam logic SFL_VALID_RST = 1'b0;
  localparam logic SFL_REJ_RST = 1'b0;
  // ==========================================================================
  // phases
  typedef enum logic [1:0] {
    SFL_PH_IDLE = 2'b00,
    SFL_PH_SETUP = 2'b01,
    SFL_PH_RUN = 2'b10
  } sfl_phase_e;
endpackage

// File: verif/test_sfl_lock_ctrl.sv
// Purpose: self-checking bench for the sequencer setting lock controller
// Assumes: inputs change on the falling edge, outputs read one falling edge later
// Notes: web 1 direct, 2 implied, 0/6/7 fixed, 4 automatic, 3/5 unrelated
`timescale 1ns/1ps
`default_nettype none
module test_sfl_lock_ctrl import sfl_pkg::*;;
  // ==========================================================================
  // stimulus and observed signals
  logic core_clk = 1'b0, reset = 1'b1;
  logic [63:0] dep = '0;
  logic [7:0] autof = 8'h10;
  logic [2:0] pick = '0, wfeat = '0, ssel = '0, sstart = '0;
  logic ebit = 1'b0, ewr = 1'b0, setup = 1'b0, run = 1'b0, wen = 1'b0, save = 1'b0, load = 1'b0;
  logic [15:0] wdata = '0;
  logic [127:0] fval;
  logic [7:0] dir, imp, fix, lck;
  logic valid, rej;
  logic [1:0] phase;
  logic [2:0] act;
  int n_fail = 0, tests_run = 0, cycles = 0;
  int seed = 32'hd4390ce1;
  logic [15:0] dv [8], iv [8];
  sfl_lock_ctrl i_dut (.core_clk_i(core_clk), .reset_i(reset), .dep_i(dep),
    .auto_feat_i(autof), .direct_setting_picker_i(pick), .direct_setting_enable_bit_i(ebit),
    .enable_wr_i(ewr), .setup_phase_switch_i(setup), .run_phase_switch_i(run), .wr_en_i(wen),
    .wr_feat_i(wfeat), .wr_data_i(wdata), .set_sel_i(ssel), .save_i(save), .load_i(load),
    .start_set_i(sstart), .feat_val_o(fval), .direct_o(dir), .implied_o(imp), .fixed_o(fix),
    .lock_o(lck), .setup_check_result_o(valid), .phase_o(phase), .active_set_o(act),
    .wr_rej_o(rej));
  // ==========================================================================
  // clock, hang guard and shared tasks
  always #2 core_clk = ~core_clk;
  // the guard is generous: the whole sequence needs well under 300 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  function automatic logic [15:0] fv(input int i);
    return fval[i*16 +: 16];
  endfunction
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one setting write; refusal flag is looked at in its single cycle
  task automatic wr(input logic [2:0] f, input logic [15:0] d, input logic exp_rej);
    @(negedge core_clk);
    wen = 1'b1;
    wfeat = f;
    wdata = d;
    @(negedge core_clk);
    wen = 1'b0;
    chk_val({15'h0, rej}, {15'h0, exp_rej});
    @(negedge core_clk);
  endtask
  task automatic cmd(input logic sv, input logic ld, input logic [2:0] s);
    @(negedge core_clk);
    save = sv;
    load = ld;
    ssel = s;
    @(negedge core_clk);
    save = 1'b0;
    load = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic sw(input logic su, input logic rn);
    @(negedge core_clk);
    setup = su;
    run = rn;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    dep[2*8+1] = 1'b1; // implied follows direct
    dep[1*8+0] = 1'b1; // direct needs 0
    dep[2*8+7] = 1'b1; // implied needs 7
    dep[7*8+6] = 1'b1; // 7 needs 6, so 6 is fixed too
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    chk_bits(lck, 8'h00);
    sw(1'b0, 1'b1);
    chk_bits({6'h0, phase}, {6'h0, SFL_PH_IDLE});
    sw(1'b0, 1'b0);
    $display("test reset and refused run done");
    wr(3'd0, 16'h00a5, 1'b0);
    @(negedge core_clk);
    pick = 3'd1;
    ebit = 1'b1;
    ewr = 1'b1;
    @(negedge core_clk);
    ewr = 1'b0;
    sw(1'b1, 1'b0);
    chk_bits(dir, 8'h02);
    chk_bits(imp, 8'h04);
    chk_bits(fix, 8'hc1);
    chk_bits(lck, 8'hc1);
    // an enable write inside setup must not move the direct class
    @(negedge core_clk);
    pick = 3'd3;
    ewr = 1'b1;
    @(negedge core_clk);
    ewr = 1'b0;
    @(negedge core_clk);
    chk_bits(dir, 8'h02);
    wr(3'd0, 16'h0bad, 1'b1);
    chk_val(fv(0), 16'h00a5);
    wr(3'd4, 16'h1234, 1'b0);
    chk_val(fv(4), 16'h1234);
    $display("test classes and setup locks done");
    for (int s = 0; s < 8; s++) begin
      dv[s] = 16'($random(seed));
      iv[s] = 16'($random(seed));
      wr(3'd1, dv[s], 1'b0);
      wr(3'd2, iv[s], 1'b0);
      cmd(1'b1, 1'b0, 3'(s));
    end
    for (int s = 7; s >= 0; s--) begin
      cmd(1'b0, 1'b1, 3'(s));
      chk_val(fv(1), dv[s]);
      chk_val(fv(2), iv[s]);
      chk_val(fv(0), 16'h00a5);
    end
    $display("test eight sets stored and restored done");
    sstart = 3'($random(seed));
    cmd(1'b0, 1'b1, sstart + 3'd1);
    sw(1'b0, 1'b0);
    chk_val({15'h0, valid}, 16'h0001);
    // both switches high in idle: run wins once the configuration is valid
    sw(1'b1, 1'b1);
    chk_bits({6'h0, phase}, {6'h0, SFL_PH_RUN});
    chk_bits({5'h0, act}, {5'h0, sstart});
    chk_bits(lck, 8'hd7);
    chk_val(fv(1), dv[sstart]);
    chk_val(fv(2), iv[sstart]);
    chk_val(fv(4), 16'h0000);
    wr(3'd2, 16'hffff, 1'b1);
    chk_val(fv(2), iv[sstart]);
    wr(3'd3, 16'h0c3c, 1'b0);
    chk_val(fv(3), 16'h0c3c);
    $display("test run locks and start set done");
    sw(1'b0, 1'b0);
    chk_bits(lck, 8'h00);
    chk_val(fv(4), 16'h1234);
    wr(3'd0, 16'h005a, 1'b0);
    cmd(1'b0, 1'b1, 3'd0);
    chk_val(fv(0), 16'h005a);
    chk_val(fv(1), dv[0]);
    $display("test fixed change outside setup done");
    complete_run();
  end
endmodule // test_sfl_lock_ctrl
`default_nettype wire
